// *** src/pcf_classifier.sv ***
// Packet classifier with filter table, APB registers and decision FIFO
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "pcf_defines.svh"

// ****************************************
// Decision FIFO
// ****************************************
module pcf_fifo #(
  parameter int W = 4,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rp_q];
  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) cnt_d = cnt_q + 1'b1;
    if (pop & ~push) cnt_d = cnt_q - 1'b1;
  end
  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(D);
      out_valid <= cnt_d != '0;
    end
  end
endmodule

// ****************************************
// Classifier top
// ****************************************
// Notes on behaviour
// - Each packet goes to exactly one stream
// - Filters test components of the key
// - Exact, prefix, range, mask, wildcard conditions
// - Default chosen only when nothing matches
// - Filter matches only if all components hold
// - Prefix compares leading bits; /0 matches all
// - Configured precedence picks winner; scheme reported
// - Later classifiers need not be complete
// - Equal precedence behaves as simultaneous
// - BA filter: exact match on DSCP only
// - Six-tuple: masked addresses, ranged ports
// - Port filters cannot match fragments
// - Free bitfield at byte offset, masked
// - Grouped filter ANDs with its successor; the successor still matches alone
// - Masked user priority, exact VLAN matching
// - Interface identifier is part of key
module pcf_classifier (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_valid,
  output logic key_ready,
  input wire logic [31:0] key_src_addr,
  input wire logic [31:0] key_dst_addr,
  input wire logic [7:0] key_proto,
  input wire logic [15:0] key_src_port,
  input wire logic [15:0] key_dst_port,
  input wire logic [5:0] key_dscp,
  input wire logic [2:0] key_user_prio,
  input wire logic [11:0] key_vlan_id,
  input wire logic [7:0] key_if_id,
  input wire logic key_frag,
  input wire logic [`PCF_HEAD_BITS-1:0] key_head,
  output logic dec_valid,
  input wire logic dec_ready,
  output logic [1:0] dec_stream,
  output logic dec_default,
  output logic dec_frag_miss
);
  localparam int NF = `PCF_NF;
  logic [31:0] filt_q [NF][`PCF_NR];
  pcf_pkg::pcf_stream_t def_q;
  logic [31:0] cnt_match_q, cnt_def_q, cnt_frag_q;
  logic [NF-1:0] raw, hit, uses_port, ba_bad, near;
  logic win_hit, better, push;
  pcf_pkg::pcf_idx_t win_idx;
  pcf_pkg::pcf_stream_t win_stream;
  logic [3:0] fifo_in, fifo_out;

  function automatic logic [31:0] pfx_mask(input logic [5:0] len);
    if (len == 6'h00) return 32'h0000_0000;
    if (len >= 6'h20) return 32'hFFFF_FFFF;
    return 32'hFFFF_FFFF << (6'h20 - len);
  endfunction

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [31:0] r);
    return v >= r[15:0] && v <= r[31:16];
  endfunction

  // ****************************************
  // Per-filter match
  // ****************************************
  always_comb begin
    logic [31:0] c, h, l2, fc, fv;
    logic [15:0] win, wm;
    logic [8:0] sh;
    logic m;
    c = '0; h = '0; l2 = '0; fc = '0; fv = '0;
    win = '0; wm = '0; sh = '0; m = 1'b0;
    for (int f = 0; f < NF; f++) begin
      c = filt_q[f][`PCF_R_CTRL];
      h = filt_q[f][`PCF_R_HDR];
      l2 = filt_q[f][`PCF_R_L2];
      fc = filt_q[f][`PCF_R_FF_CFG];
      fv = filt_q[f][`PCF_R_FF_VAL];
      uses_port[f] = ~c[`PCF_C_BA] &
                     (filt_q[f][`PCF_R_SPORT] != 32'hFFFF_0000 ||
                      filt_q[f][`PCF_R_DPORT] != 32'hFFFF_0000);
      ba_bad[f] = key_dscp != h[14:9];
      if (c[`PCF_C_BA]) begin
        m = ~ba_bad[f];
      end else begin
        // All components must hold; zero mask means don't care
        m = ((key_src_addr ^ filt_q[f][`PCF_R_SRC_VAL]) &
             filt_q[f][`PCF_R_SRC_MASK]) == 32'h0000_0000;
        m &= ((key_dst_addr ^ filt_q[f][`PCF_R_DST_VAL]) &
              pfx_mask(filt_q[f][`PCF_R_DST_CFG][5:0])) == '0;
        m &= in_range(key_src_port, filt_q[f][`PCF_R_SPORT]);
        m &= in_range(key_dst_port, filt_q[f][`PCF_R_DPORT]);
        m &= ~h[8] | (key_proto == h[7:0]);
        m &= ~h[15] | ~ba_bad[f];
        m &= ((key_user_prio ^ h[18:16]) & h[21:19]) == 3'h0;
        m &= ~l2[12] | (key_vlan_id == l2[11:0]);
        m &= ~l2[21] | (key_if_id == l2[20:13]);
        // Field may start at any byte up to 30 of the captured head
        sh = 9'd240 - {1'b0, fc[4:0], 3'b000};
        win = 16'(key_head >> sh);
        wm = 16'((17'h1_0000 >> (5'd16 - fc[9:5])) - 17'h1);
        win = win >> (5'd16 - fc[9:5]);
        if (fc[10]) begin
          m &= fc[4:0] <= 5'd30 && fc[9:5] != 5'd0 &&
               fc[9:5] <= 5'd16 &&
               ((win ^ fv[15:0]) & fv[31:16] & wm) == '0;
        end
      end
      near[f] = c[`PCF_C_EN] & m & uses_port[f];
      raw[f] = c[`PCF_C_EN] & m & ~(key_frag & uses_port[f]);
    end
    for (int f = 0; f < NF; f++) begin
      // Grouped filter needs its successor to match as well
      hit[f] = raw[f];
      if (filt_q[f][`PCF_R_CTRL][`PCF_C_GRP]) begin
        hit[f] = raw[f] & (f < NF-1 ? raw[(f+1)%NF] : 1'b0);
      end
    end
  end

  // ****************************************
  // Precedence and selection
  // ****************************************
  always_comb begin
    win_hit = 1'b0;
    win_idx = '0;
    // Lower value wins; equal precedence falls to the lowest index
    for (int f = NF-1; f >= 0; f--) begin
      if (hit[f] && (!win_hit || filt_q[f][`PCF_R_CTRL][`PCF_C_PREC] <=
          filt_q[win_idx][`PCF_R_CTRL][`PCF_C_PREC])) begin
        win_hit = 1'b1;
        win_idx = pcf_pkg::pcf_idx_t'(f);
      end
    end
    win_stream = win_hit ? filt_q[win_idx][`PCF_R_CTRL][`PCF_C_OUT] :
                 def_q;
    better = 1'b0;
    for (int f = 0; f < NF; f++) begin
      if (hit[f] && filt_q[f][`PCF_R_CTRL][`PCF_C_PREC] <
          filt_q[win_idx][`PCF_R_CTRL][`PCF_C_PREC]) better = 1'b1;
    end
  end

  assign push = key_valid & key_ready;
  assign fifo_in = {key_frag & |near & ~win_hit,
                    ~win_hit, win_stream};

  // Decisions queue in arrival order; full FIFO stalls the parser
  pcf_fifo #(.W(`PCF_FIFO_WIDTH), .D(`PCF_FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(key_valid),
    .in_ready(key_ready),
    .in_data(fifo_in),
    .out_valid(dec_valid),
    .out_ready(dec_ready),
    .out_data(fifo_out)
  );
  assign dec_stream = fifo_out[1:0];
  assign dec_default = fifo_out[2];
  assign dec_frag_miss = fifo_out[3];

  // ****************************************
  // APB slave
  // ****************************************
  logic wr_en, unmapped;
  logic [1:0] a_f;
  logic [3:0] a_r;
  assign a_f = paddr[7:6];
  assign a_r = paddr[5:2];
  assign wr_en = psel & penable & pwrite;
  always_comb begin
    unmapped = 1'b0;
    if (paddr[1:0] != 2'b00) unmapped = 1'b1;
    else if (paddr[11:8] == 4'h0) unmapped = a_r >= 4'(`PCF_NR);
    else unmapped = !(paddr == `PCF_A_DEFAULT ||
      paddr == `PCF_A_PREC_INFO || paddr == `PCF_A_CNT_MATCH ||
      paddr == `PCF_A_CNT_DEFAULT || paddr == `PCF_A_CNT_FRAG);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int f = 0; f < NF; f++) begin
        for (int r = 0; r < `PCF_NR; r++) begin
          filt_q[f][r] <= 32'h0000_0000;
        end
        filt_q[f][`PCF_R_SPORT] <= 32'hFFFF_0000;
        filt_q[f][`PCF_R_DPORT] <= 32'hFFFF_0000;
      end
      def_q <= '0;
    end else if (wr_en && !unmapped) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          if (paddr[11:8] == 4'h0) begin
            filt_q[a_f][a_r][8*b+:8] <= pwdata[8*b+:8];
          end else if (paddr == `PCF_A_DEFAULT && b == 0) begin
            def_q <= pwdata[1:0];
          end
        end
      end
    end
  end

  // Counters clear on a write to their own address; a count in the same cycle still lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_match_q <= '0;
      cnt_def_q <= '0;
      cnt_frag_q <= '0;
    end else begin
      if (wr_en && paddr == `PCF_A_CNT_MATCH)
        cnt_match_q <= {31'h0, push & win_hit};
      else if (push && win_hit) cnt_match_q <= cnt_match_q + 1'b1;
      if (wr_en && paddr == `PCF_A_CNT_DEFAULT)
        cnt_def_q <= {31'h0, push & ~win_hit};
      else if (push && !win_hit) cnt_def_q <= cnt_def_q + 1'b1;
      if (wr_en && paddr == `PCF_A_CNT_FRAG)
        cnt_frag_q <= {31'h0, push & fifo_in[3]};
      else if (push && fifo_in[3]) cnt_frag_q <= cnt_frag_q + 1'b1;
    end
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= unmapped;
        prdata <= '0;
        if (!unmapped) begin
          if (paddr[11:8] == 4'h0) prdata <= filt_q[a_f][a_r];
          else if (paddr == `PCF_A_DEFAULT) prdata <= {30'h0, def_q};
          else if (paddr == `PCF_A_PREC_INFO)
            prdata <= `PCF_PREC_SCHEME;
          else if (paddr == `PCF_A_CNT_MATCH) prdata <= cnt_match_q;
          else if (paddr == `PCF_A_CNT_DEFAULT) prdata <= cnt_def_q;
          else prdata <= cnt_frag_q;
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_default_last;
    @(posedge pclk) disable iff (!presetn) push && |hit |-> !fifo_in[2];
  endproperty
  a_default_last: assert property (p_default_last)
    else $error("default chosen while a filter matched");
  property p_stream_of_winner;
    @(posedge pclk) disable iff (!presetn) push && win_hit |->
      hit[win_idx] && fifo_in[1:0] == filt_q[win_idx][`PCF_R_CTRL][4:3];
  endproperty
  a_stream_of_winner: assert property (p_stream_of_winner)
    else $error("stream differs from winning filter");
  property p_precedence;
    @(posedge pclk) disable iff (!presetn) push |-> !better;
  endproperty
  a_precedence: assert property (p_precedence)
    else $error("higher precedence filter was passed over");
  property p_frag;
    @(posedge pclk) disable iff (!presetn)
      push && key_frag |-> (hit & uses_port) == '0;
  endproperty
  a_frag: assert property (p_frag)
    else $error("port filter matched a fragment");
  property p_ba;
    @(posedge pclk) disable iff (!presetn) push |->
      (hit & ba_bad & {filt_q[3][0][6], filt_q[2][0][6],
       filt_q[1][0][6], filt_q[0][0][6]}) == '0;
  endproperty
  a_ba: assert property (p_ba)
    else $error("BA filter matched a different DSCP");
  property p_order;
    @(posedge pclk) disable iff (!presetn) push |=> dec_valid;
  endproperty
  a_order: assert property (p_order)
    else $error("accepted decision not queued");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      dec_valid && !dec_ready |=> dec_valid && $stable(fifo_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("decision changed while stalled");
  property p_def_count;
    @(posedge pclk) disable iff (!presetn)
      push && !win_hit && !wr_en |=> cnt_def_q == $past(cnt_def_q) + 1;
  endproperty
  a_def_count: assert property (p_def_count)
    else $error("default count did not advance");
  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn) psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("access phase without ready");
  c_default: cover property (@(posedge pclk) push && !win_hit);
  c_overlap: cover property (@(posedge pclk) push && $countones(hit) > 1);
  c_full: cover property (@(posedge pclk) key_valid && !key_ready);
endmodule

// *** inc/pcf_defines.svh ***
// Register map, field positions and sizes of the packet classifier
`ifndef PCF_DEFINES_SVH
`define PCF_DEFINES_SVH
`define PCF_NF 4
`define PCF_NR 11
`define PCF_HEAD_BITS 256
`define PCF_FIFO_DEPTH 16
`define PCF_FIFO_WIDTH 4
// Per-filter word index, filter f at byte f*0x40
`define PCF_R_CTRL 4'h0
`define PCF_R_SRC_VAL 4'h1
`define PCF_R_SRC_MASK 4'h2
`define PCF_R_DST_VAL 4'h3
`define PCF_R_DST_CFG 4'h4
`define PCF_R_SPORT 4'h5
`define PCF_R_DPORT 4'h6
`define PCF_R_HDR 4'h7
`define PCF_R_L2 4'h8
`define PCF_R_FF_CFG 4'h9
`define PCF_R_FF_VAL 4'hA
// Global registers
`define PCF_A_DEFAULT 12'h100
`define PCF_A_PREC_INFO 12'h104
`define PCF_A_CNT_MATCH 12'h108
`define PCF_A_CNT_DEFAULT 12'h10C
`define PCF_A_CNT_FRAG 12'h110
`define PCF_PREC_SCHEME 32'h0000_0001
// CTRL fields
`define PCF_C_EN 0
`define PCF_C_PREC 2:1
`define PCF_C_OUT 4:3
`define PCF_C_GRP 5
`define PCF_C_BA 6
`endif

// *** inc/pcf_pkg.sv ***
// Types shared by the packet classifier
package pcf_pkg;
  typedef logic [1:0] pcf_stream_t;
  typedef logic [1:0] pcf_prec_t;
  typedef logic [1:0] pcf_idx_t;
endpackage

// *** tb/pcf_consumer_model.sv ***
// Downstream consumer model that takes classifier decisions
`timescale 1ns/10ps

module pcf_consumer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dec_valid,
  input wire logic stall,
  input wire logic slow,
  output logic dec_ready
);
  logic [7:0] lfsr_q;

  // Random gaps mimic a congested queue behind the classifier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= 8'h5A;
      dec_ready <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      dec_ready <= !stall && (!slow || lfsr_q[0]);
    end
  end
endmodule

// *** tb/pcf_classifier_tb.sv ***
// Self-checking bench of the packet classifier
`timescale 1ns/10ps
`include "pcf_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end

module pcf_classifier_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, r;
  logic [31:0] seed = 32'h0001_6239;
  logic pready, pslverr, err, key_ready, dec_valid, dec_ready;
  logic key_valid = 1'b0;
  logic [31:0] k_src = 32'h0;
  logic [31:0] k_dst = 32'h0;
  logic [7:0] k_proto = 8'h0;
  logic [7:0] k_if = 8'h0;
  logic [15:0] k_sp = 16'h0;
  logic [15:0] k_dp = 16'h0;
  logic [5:0] k_dscp = 6'h0;
  logic [2:0] k_prio = 3'h0;
  logic [11:0] k_vlan = 12'h0;
  logic k_frag = 1'b0;
  logic [255:0] k_head = 256'h0;
  logic [1:0] dec_stream;
  logic dec_default, dec_frag_miss;
  logic stall = 1'b0;
  logic slow = 1'b1;
  logic [3:0] exp_q[$];
  logic [3:0] e;
  logic [3:0] ex_t;
  logic fix = 1'b0;
  logic [7:0] fx_if = 8'h00;
  logic [11:0] fx_vlan = 12'h000;
  logic [255:0] fx_head = 256'h0;
  int mismatches = 0;
  int compares = 0;

  always #2.5 pclk = ~pclk;

  pcf_classifier uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_valid(key_valid), .key_ready(key_ready), .key_src_addr(k_src),
    .key_dst_addr(k_dst), .key_proto(k_proto), .key_src_port(k_sp),
    .key_dst_port(k_dp), .key_dscp(k_dscp), .key_user_prio(k_prio),
    .key_vlan_id(k_vlan), .key_if_id(k_if), .key_frag(k_frag),
    .key_head(k_head), .dec_valid(dec_valid), .dec_ready(dec_ready),
    .dec_stream(dec_stream), .dec_default(dec_default),
    .dec_frag_miss(dec_frag_miss));

  pcf_consumer_model u_cons (.pclk(pclk), .presetn(presetn),
    .dec_valid(dec_valid), .stall(stall), .slow(slow),
    .dec_ready(dec_ready));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] fa(input int f, input logic [3:0] w);
    return 12'(f * 64) + {6'h00, w, 2'h0};
  endfunction

  // Idle edge after release keeps psel from being assigned twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send(input logic [31:0] s, input logic [31:0] d,
    input logic [15:0] sp, input logic [5:0] ds, input logic fr,
    input logic [2:0] pr, input logic [3:0] ex);
    logic [31:0] v;
    v = xs();
    key_valid <= 1'b1;
    k_src <= s;
    k_dst <= d;
    k_sp <= sp;
    k_dscp <= ds;
    k_frag <= fr;
    k_prio <= pr;
    k_proto <= v[7:0];
    k_if <= fix ? fx_if : v[15:8];
    k_vlan <= fix ? fx_vlan : v[27:16];
    k_dp <= 16'(xs() >> 16);
    k_head <= fix ? fx_head : {8{xs()}};
    @(posedge pclk);
    while (key_ready !== 1'b1) @(posedge pclk);
    exp_q.push_back(ex);
  endtask

  task automatic kv_off();
    key_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic drain(input string n);
    while (exp_q.size() != 0) @(posedge pclk);
    $display("Test %s finished", n);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Oldest expectation against each decision taken
  always @(posedge pclk) begin
    if (presetn === 1'b1 && dec_valid === 1'b1 && dec_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("MISMATCH t=%0t unexpected decision", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK({dec_frag_miss, dec_default, dec_stream}, e)
      end
    end
  end

  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, fa(0, `PCF_R_SPORT), 32'h0);
    `CHK(rd, 32'hFFFF_0000)
    apb(1'b0, `PCF_A_PREC_INFO, 32'h0);
    `CHK(rd, `PCF_PREC_SCHEME)
    apb(1'b0, 12'h200, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `PCF_A_DEFAULT, 32'h3);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      send({8'h0A, r[23:0]}, r, r[15:0], r[5:0], 1'b0, 3'h0, 4'h7);
    end
    kv_off();
    drain("default");
    // Source /24 under mask, destination /24 prefix
    apb(1'b1, fa(0, `PCF_R_SRC_VAL), 32'hAC1F_0800);
    apb(1'b1, fa(0, `PCF_R_SRC_MASK), 32'hFFFF_FF00);
    apb(1'b1, fa(0, `PCF_R_DST_VAL), 32'hAC1F_0300);
    apb(1'b1, fa(0, `PCF_R_DST_CFG), 32'h18);
    apb(1'b1, fa(0, `PCF_R_CTRL), 32'h0B);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      send({24'hAC1F08, r[7:0]}, {24'hAC1F03, r[15:8]}, r[31:16], 6'h0,
        1'b0, 3'h0, 4'h1);
      send({24'hAC1F08, r[7:0]}, {24'hAC1F04, r[15:8]}, r[31:16], 6'h0,
        1'b0, 3'h0, 4'h7);
    end
    kv_off();
    drain("masked prefix");
    // Catch-all at /0 swept through lower, equal, higher precedence
    for (int p = 2; p >= 0; p--) begin
      apb(1'b1, fa(1, `PCF_R_CTRL), 32'(17 + 2 * p));
      r = xs();
      send(32'hAC1F_0805, 32'hAC1F_03FE, r[15:0], 6'h0, 1'b0, 3'h0,
        (p == 0) ? 4'h2 : 4'h1);
      send(r, ~r, r[15:0], 6'h0, 1'b0, 3'h0, 4'h2);
      kv_off();
      drain("precedence");
    end
    apb(1'b1, fa(1, `PCF_R_CTRL), 32'h0);
    apb(1'b1, fa(2, `PCF_R_SPORT), 32'h0014_0014);
    apb(1'b1, fa(2, `PCF_R_CTRL), 32'h01);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      send({8'h0A, r[23:0]}, r, 16'(i == 3 ? 20 : 19 + i), 6'h0, i == 3, 3'h0,
        (i == 1) ? 4'h0 : ((i == 3) ? 4'hF : 4'h7));
    end
    kv_off();
    drain("port range");
    apb(1'b0, `PCF_A_CNT_FRAG, 32'h0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b1, fa(2, `PCF_R_CTRL), 32'h0);
    apb(1'b1, fa(3, `PCF_R_HDR), 32'h0000_F000);
    apb(1'b1, fa(3, `PCF_R_CTRL), 32'h51);
    for (int d = 0; d < 64; d++) begin
      r = xs();
      send({8'h0A, r[23:0]}, r, r[15:0], 6'(d), 1'b0, r[18:16],
        (d == 8'h38) ? 4'h2 : 4'h7);
    end
    kv_off();
    drain("exact code point");
    apb(1'b1, fa(3, `PCF_R_HDR), 32'h0034_0000);
    apb(1'b1, fa(3, `PCF_R_CTRL), 32'h09);
    for (int p = 0; p < 8; p++) begin
      r = xs();
      send({8'h0A, r[23:0]}, r, r[15:0], r[5:0], 1'b0, 3'(p),
        (p / 2 == 2) ? 4'h1 : 4'h7);
    end
    kv_off();
    drain("user priority");
    apb(1'b1, fa(3, `PCF_R_CTRL), 32'h0);
    // Grouped free-form field with VLAN and interface filter
    apb(1'b1, fa(2, `PCF_R_SPORT), 32'hFFFF_0000);
    apb(1'b1, fa(2, `PCF_R_FF_CFG), 32'h0000_0470);
    apb(1'b1, fa(2, `PCF_R_FF_VAL), 32'h0005_0004);
    apb(1'b1, fa(2, `PCF_R_CTRL), 32'h0000_0029);
    apb(1'b1, fa(3, `PCF_R_HDR), 32'h0000_0000);
    apb(1'b1, fa(3, `PCF_R_L2), 32'h002B_5900);
    apb(1'b1, fa(3, `PCF_R_CTRL), 32'h0000_0013);
    fix = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      fx_head = {8{xs()}};
      fx_head[127] = i[2];
      fx_head[125] = r[31] & ~i[2];
      fx_vlan = i[0] ? 12'h900 : r[11:0];
      fx_if = i[1] ? 8'h5A : r[23:16];
      ex_t = (fx_vlan != 12'h900 || fx_if != 8'h5A) ? 4'h7 :
             (fx_head[127] && !fx_head[125]) ? 4'h1 : 4'h2;
      send({8'h0A, r[23:0]}, r, r[15:0], r[5:0], 1'b0, 3'h0,
        ex_t);
    end
    kv_off();
    drain("grouped fields");
    fix = 1'b0;
    apb(1'b1, fa(2, `PCF_R_CTRL), 32'h0);
    apb(1'b1, fa(3, `PCF_R_CTRL), 32'h0);
    // Consumer halted, sixteen decisions fill the queue
    stall <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      send({8'h0A, r[23:0]}, r, r[15:0], r[5:0], 1'b0, 3'h0, 4'h7);
    end
    kv_off();
    repeat (3) @(posedge pclk);
    `CHK(key_ready, 1'b0)
    stall <= 1'b0;
    slow <= 1'b0;
    // Refused while full, taken once the consumer drains
    send({8'h0A, r[23:0]}, r, r[15:0], r[5:0], 1'b0, 3'h0, 4'h7);
    kv_off();
    drain("queue full");
    print_verdict();
  end
endmodule
